/* File: src/pulse_ref_params.svh */
`ifndef PULSE_REF_PARAMS_SVH
`define PULSE_REF_PARAMS_SVH
// ==========================================================================
// Register byte offsets
`define OFS_MODE      8'h00
`define OFS_PULSECFG  8'h04
`define OFS_GEARNUM   8'h08
`define OFS_GEARDEN   8'h0C
`define OFS_INDIST    8'h10
`define OFS_ERROR     8'h14
`define OFS_STATUS    8'h18
// ==========================================================================
// Field positions and codes
`define MODE_POS_TRAIN     12'h001
`define MODE_RELOAD_BIT    16
`define CFG_ACT_LSB        0
`define CFG_FORM_LSB       4
`define CFG_INV_LSB        8
`define DIST_SEL_W         3
// ==========================================================================
// Reset values
`define MODE_RESET     12'h000
`define CFG_RESET      12'h000
`define GEAR_RESET     16'h0001
`define DIST_RESET     3'h0
// ==========================================================================
// Encoder lines per revolution, counted at four times
`define ENC_LINES_INC  2500
`define ENC_LINES_BUS  32768
`define ENC_MULT       4
// ==========================================================================
// Host-side timing figures
`define SERVO_ON_WAIT_MS  40
`define CLEAR_HOLD_US     200
`define CLK_MHZ           250
`define CLEAR_HOLD_CYC    (`CLEAR_HOLD_US * `CLK_MHZ)
`endif

/* File: src/pulse_ref_pkg.sv */
package pulse_ref_pkg;
  // ========================================================================
  // Reference pulse forms
  typedef enum logic [2:0] {
    FORM_SIGN_PULSE,
    FORM_CW_CCW,
    FORM_QUAD_X1,
    FORM_QUAD_X2,
    FORM_QUAD_X4
  } pulse_form_t;

  // ========================================================================
  // Offset counter clear actions
  typedef enum logic [1:0] {
    ACT_CLR_SERVO_OFF,
    ACT_RETAIN,
    ACT_RETAIN_ZCLAMP
  } clear_act_t;
endpackage

/* File: src/pulse_train_position_reference.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pulse_ref_params.svh"
module pulse_train_position_reference #(
  parameter int ERR_W  = 32,
  parameter int TERM_N = 8
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Reference pins from host
  input  wire logic               refPulseInP,
  input  wire logic               refPulseInN,
  input  wire logic               refSignInP,
  input  wire logic               refSignInN,
  // Encoder and drive state pins
  input  wire logic               encA,
  input  wire logic               encB,
  input  wire logic               servoOn,
  input  wire logic               overtravel,
  input  wire logic               zeroClamp,
  input  wire logic [TERM_N-1:0]  inTerm_n,
  // Position loop outputs
  output logic signed [ERR_W-1:0] posError,
  output logic                    posLoopEnable
);
  import pulse_ref_pkg::*;

  localparam int NPIN = 9 + TERM_N;
  localparam logic [NPIN-1:0] PIN_RST = {{TERM_N{1'b1}}, 9'h000};

  // Assertion defaults
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ========================================================================
  // Pin synchronisers and agreement filter
  wire logic [NPIN-1:0] pinRaw = {inTerm_n, zeroClamp, overtravel, servoOn, encB, encA,
                                  refSignInN, refSignInP, refPulseInN, refPulseInP};
  logic [NPIN-1:0] s1Reg;
  logic [NPIN-1:0] s2Reg;
  logic [NPIN-1:0] s3Reg;
  logic [NPIN-1:0] pinReg;
  for (genvar g = 0; g < NPIN; g++)
  begin : gSync
    // Value counts once second and third stage agree
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        s1Reg[g]  <= PIN_RST[g];
        s2Reg[g]  <= PIN_RST[g];
        s3Reg[g]  <= PIN_RST[g];
        pinReg[g] <= PIN_RST[g];
      end
      else
      begin
        s1Reg[g] <= pinRaw[g];
        s2Reg[g] <= s1Reg[g];
        s3Reg[g] <= s2Reg[g];
        if (s2Reg[g] == s3Reg[g])
          pinReg[g] <= s3Reg[g];
      end
    end
  end
  AST_FILTER: assert property ($changed(pinReg[0]) |-> $past(s2Reg[0] == s3Reg[0]))
    else $error("Pulse pin changed without stage agreement");

  // ========================================================================
  // Register file
  logic [11:0] modeReg;
  logic [11:0] cfgReg;
  logic [15:0] numShadowReg;
  logic [15:0] denShadowReg;
  logic [15:0] numActReg;
  logic [15:0] denActReg;
  logic [`DIST_SEL_W-1:0] distReg;
  wire logic setupPh  = psel & ~penable;
  wire logic wrAcc    = psel & penable & pwrite;
  wire logic selMode  = (paddr == `OFS_MODE);
  wire logic selCfg   = (paddr == `OFS_PULSECFG);
  wire logic selNum   = (paddr == `OFS_GEARNUM);
  wire logic selDen   = (paddr == `OFS_GEARDEN);
  wire logic selDist  = (paddr == `OFS_INDIST);
  wire logic selErr   = (paddr == `OFS_ERROR);
  wire logic selStat  = (paddr == `OFS_STATUS);
  wire logic mapped   = selMode | selCfg | selNum | selDen | selDist | selErr | selStat;
  wire logic reload   = wrAcc & selMode & pwdata[`MODE_RELOAD_BIT];
  wire logic wrNumOk  = wrAcc & selNum & (pwdata[15:0] != 16'h0000);
  wire logic wrDenOk  = wrAcc & selDen & (pwdata[15:0] != 16'h0000);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Software-written registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeReg      <= `MODE_RESET;
      cfgReg       <= `CFG_RESET;
      numShadowReg <= `GEAR_RESET;
      denShadowReg <= `GEAR_RESET;
      distReg      <= `DIST_RESET;
    end
    else
    begin
      if (wrAcc & selMode)
        modeReg <= pwdata[11:0];
      if (wrAcc & selCfg)
        cfgReg <= pwdata[11:0];
      if (wrNumOk)
        numShadowReg <= pwdata[15:0];
      if (wrDenOk)
        denShadowReg <= pwdata[15:0];
      if (wrAcc & selDist)
        distReg <= pwdata[`DIST_SEL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      numActReg <= `GEAR_RESET;
      denActReg <= `GEAR_RESET;
    end
    else if (reload)
    begin
      numActReg <= numShadowReg;
      denActReg <= denShadowReg;
    end
  end
  AST_GEAR_NZ: assert property (numActReg != 16'h0000 && denActReg != 16'h0000)
    else $error("Active gear term is zero");
  AST_GEAR_HOLD: assert property (!reload |=> $stable(numActReg) && $stable(denActReg))
    else $error("Active gear changed without reboot");

  // ========================================================================
  // Decoded configuration and drive conditions
  wire logic [3:0] actDig  = cfgReg[`CFG_ACT_LSB +: 4];
  wire logic [3:0] formDig = cfgReg[`CFG_FORM_LSB +: 4];
  wire logic [3:0] invDig  = cfgReg[`CFG_INV_LSB +: 4];
  pulse_form_t form;
  clear_act_t  clrAct;
  // Unused digit codes fall back to code 0
  assign form   = (formDig <= 4'h4) ? pulse_form_t'(formDig[2:0]) : FORM_SIGN_PULSE;
  assign clrAct = (actDig <= 4'h2) ? clear_act_t'(actDig[1:0]) : ACT_CLR_SERVO_OFF;
  wire logic modeOk = (modeReg == `MODE_POS_TRAIN);
  wire logic [TERM_N-1:0] termLvl_n = pinReg[NPIN-1:9];
  wire logic clearIn   = ~termLvl_n[distReg];
  wire logic servoLvl  = pinReg[6];
  wire logic otLvl     = pinReg[7];
  wire logic zcLvl     = pinReg[8];
  // servo off clears under action 0
  wire logic clrServo  = (clrAct == ACT_CLR_SERVO_OFF) & ~servoLvl;
  // retain under action 1; zero clamp clears under action 2 with servo off or overtravel
  wire logic clrZc     = (clrAct == ACT_RETAIN_ZCLAMP) & zcLvl & (~servoLvl | otLvl);
  wire logic zeroing   = ~modeOk | clearIn | clrServo | clrZc;

  // ========================================================================
  // Input levels and inversion
  wire logic pulseLvl = pinReg[0] & ~pinReg[1];
  wire logic signLvl  = pinReg[2] & ~pinReg[3];
  // digits 0, 2, 3 invert pulse
  wire logic invPulse = (invDig != 4'h1);
  wire logic pulseIn  = pulseLvl ^ invPulse;
  wire logic signIn   = signLvl ^ ~invPulse;
  AST_INV: assert property (invDig == 4'h0 |-> pulseIn == ~pulseLvl && signIn == signLvl)
    else $error("Inversion digit 0 mishandled");
  AST_INV1: assert property (invDig == 4'h1 |-> pulseIn == pulseLvl && signIn == ~signLvl)
    else $error("Inversion digit 1 mishandled");
  // Previous levels for edge detection, {encB, encA, sign, pulse}
  logic [3:0] prevReg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prevReg <= 4'h0;
    else
      prevReg <= {pinReg[5], pinReg[4], signIn, pulseIn};
  end
  // Four-edge quadrature step, {up, down}
  function automatic logic [1:0] quad4(input logic aN, input logic bN,
                                       input logic aP, input logic bP);
    logic one;
    one = (aN ^ aP) ^ (bN ^ bP);
    quad4 = {one & (aN ^ bP), one & (aP ^ bN)};
  endfunction

  // ========================================================================
  // Reference decoding
  wire logic       pulseRise = pulseIn & ~prevReg[0];
  wire logic       signRise  = signIn & ~prevReg[1];
  wire logic       aEdge     = pulseIn ^ prevReg[0];
  wire logic       bEdge     = signIn ^ prevReg[1];
  wire logic [1:0] refQ4     = quad4(pulseIn, signIn, prevReg[0], prevReg[1]);
  // sign level or own line sets direction
  wire logic spUp = pulseRise & ~signIn;
  wire logic spDn = pulseRise & signIn;
  wire logic cwUp = pulseRise & ~signRise;
  wire logic cwDn = signRise & ~pulseRise;
  // x1 A rises, x2 A edges
  wire logic x1Up = pulseRise & ~bEdge & ~signIn;
  wire logic x1Dn = pulseRise & ~bEdge & signIn;
  wire logic x2Up = aEdge & ~bEdge & (pulseIn ^ signIn);
  wire logic x2Dn = aEdge & ~bEdge & ~(pulseIn ^ signIn);
  wire logic refUp = (form == FORM_SIGN_PULSE) ? spUp : (form == FORM_CW_CCW) ? cwUp :
                     (form == FORM_QUAD_X1) ? x1Up : (form == FORM_QUAD_X2) ? x2Up : refQ4[1];
  wire logic refDn = (form == FORM_SIGN_PULSE) ? spDn : (form == FORM_CW_CCW) ? cwDn :
                     (form == FORM_QUAD_X1) ? x1Dn : (form == FORM_QUAD_X2) ? x2Dn : refQ4[0];
  AST_X1: assert property (form == FORM_QUAD_X1 && !pulseIn && prevReg[0]
                           |-> !refUp && !refDn)
    else $error("Quadrature x1 counted a falling edge");
  AST_CWCCW: assert property (form == FORM_CW_CCW && signRise && !pulseRise
                              |-> refDn && !refUp)
    else $error("CCW pulse not counted negative");
  wire logic [1:0] fbQ4 = quad4(pinReg[4], pinReg[5], prevReg[2], prevReg[3]);
  // ========================================================================
  // Electronic gear and offset counter
  logic signed [17:0] remReg;
  logic signed [ERR_W-1:0] errReg;
  wire logic signed [17:0] numS = $signed({2'b00, numActReg});
  wire logic signed [17:0] denS = $signed({2'b00, denActReg});
  wire logic signed [17:0] gearSum = refUp ? (remReg + numS) : (remReg - numS);
  wire logic signed [17:0] gearQuo = gearSum / denS;
  wire logic signed [17:0] gearRem = gearSum % denS;
  wire logic refStep = refUp | refDn;
  wire logic signed [ERR_W-1:0] refAdd = refStep ? ERR_W'(gearQuo) : '0;
  wire logic signed [ERR_W-1:0] fbSub  = fbQ4[1] ? ERR_W'(1) : (fbQ4[0] ? -ERR_W'(1) : '0);
  wire logic signed [ERR_W-1:0] err_next = errReg + refAdd - fbSub;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      errReg <= '0;
      remReg <= '0;
    end
    else if (zeroing)
    begin
      errReg <= '0;
      remReg <= '0;
    end
    else
    begin
      errReg <= err_next;
      if (refStep)
        remReg <= gearRem;
    end
  end
  assign posError = errReg;
  assign posLoopEnable = modeOk & servoLvl & ~clearIn & ~zeroing;

  AST_CLEAR: assert property (clearIn |=> errReg == '0)
    else $error("Clear did not zero offset counter");
  AST_LOOP_OFF: assert property (clearIn |-> !posLoopEnable)
    else $error("Position loop active during clear");
  AST_MODE: assert property (!modeOk |-> !posLoopEnable ##1 errReg == '0)
    else $error("Counting outside position pulse-train mode");
  AST_SERVO_OFF: assert property (clrAct == ACT_CLR_SERVO_OFF && !servoLvl
                                  |=> errReg == '0)
    else $error("Servo off did not clear under action 0");
  AST_RETAIN: assert property (clrAct == ACT_RETAIN && modeOk && !clearIn && !refStep
                               && fbQ4 == 2'b00 |=> $stable(errReg))
    else $error("Offset counter lost under retain action");
  sequence seqRefOnly;
    !zeroing && refStep && fbQ4 == 2'b00;
  endsequence
  AST_GEAR: assert property (seqRefOnly |=> errReg == $past(errReg) + ERR_W'($past(gearQuo)))
    else $error("Geared step not added to counter");

  // ========================================================================
  // Read data, registered in the setup phase
  wire logic [31:0] statWord = {28'h0000000, zeroing, clearIn, modeOk, posLoopEnable};
  wire logic [31:0] rdMux =
    selMode ? {20'h00000, modeReg} :
    selCfg  ? {20'h00000, cfgReg} :
    selNum  ? {16'h0000, numShadowReg} :
    selDen  ? {16'h0000, denShadowReg} :
    selDist ? {29'h0, distReg} :
    selErr  ? 32'(errReg) :
    selStat ? statWord : 32'h00000000;
  // Capture read word
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else if (setupPh & ~pwrite)
      prdata <= rdMux;
  end
endmodule // pulse_train_position_reference
`default_nettype wire

/* File: verif/host_pulse_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host controller driving the reference pairs
module host_pulse_model (
  // Clock
  input  wire logic clk,
  // Reference pairs
  output logic      refPulseInP,
  output logic      refPulseInN,
  output logic      refSignInP,
  output logic      refSignInN
);
  logic pInv;
  logic sInv;

  // Idle pairs at power up
  initial
  begin
    pInv = 1'b1;
    sInv = 1'b0;
    refPulseInP = 1'b1;
    refPulseInN = 1'b0;
    refSignInP  = 1'b0;
    refSignInN  = 1'b1;
  end

  // One logical level pair, held eight clocks
  task automatic level(input logic p, input logic s);
    @(posedge clk);
    refPulseInP <= p ^ pInv;
    refPulseInN <= ~(p ^ pInv);
    refSignInP  <= s ^ sInv;
    refSignInN  <= ~(s ^ sInv);
    repeat (7) @(posedge clk);
  endtask

  task automatic setup(input int inv);
    pInv = (inv == 0);
    sInv = (inv == 1);
    level(1'b0, 1'b0);
  endtask

  task automatic send(input int form, input int n, input bit neg);
    for (int i = 0; i < n; i++)
    begin
      case (form)
        0:
        begin
          level(1'b0, neg);
          level(1'b1, neg);
          level(1'b0, neg);
        end
        1:
        begin
          level(!neg, neg);
          level(1'b0, 1'b0);
        end
        default:
        begin
          level(!neg, neg);
          level(1'b1, 1'b1);
          level(neg, !neg);
          level(1'b0, 1'b0);
        end
      endcase
    end
  endtask
endmodule // host_pulse_model
`default_nettype wire

/* File: verif/pulse_train_position_reference_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pulse_ref_params.svh"
// ==========================================
// Bench with integer model of the offset counter
module pulse_train_position_reference_tb;
  logic        clk, rst_b, psel, penable, pwrite, encA, encB;
  logic        servoOn, overtravel, zeroClamp, pready, pslverr, posLoopEnable, er;
  logic [7:0]  paddr, inTerm_n;
  logic [31:0] pwdata, prdata, rd;
  logic signed [31:0] posError;
  wire logic   refPulseInP, refPulseInN, refSignInP, refSignInN;
  int          errors, n_compared, num, den;
  longint      expErr, rem, q;
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
  int          at [5][4] = '{'{0,0,0,0}, '{0,1,1,0}, '{1,0,1,0}, '{2,0,0,0}, '{2,0,0,1}};
  bit          zr [5] = '{1, 0, 0, 0, 1};

  pulse_train_position_reference dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refPulseInP(refPulseInP),
    .refPulseInN(refPulseInN), .refSignInP(refSignInP), .refSignInN(refSignInN),
    .encA(encA), .encB(encB), .servoOn(servoOn), .overtravel(overtravel),
    .zeroClamp(zeroClamp), .inTerm_n(inTerm_n), .posError(posError),
    .posLoopEnable(posLoopEnable));
  host_pulse_model hp (.clk(clk), .refPulseInP(refPulseInP), .refPulseInN(refPulseInN),
    .refSignInP(refSignInP), .refSignInN(refSignInN));

  // Clock
  always #2 clk = ~clk;

  // Verdict and end of run
  task automatic finish_test;
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_chk(input logic [31:0] exp);
    repeat (12) @(posedge clk);
    chk(posError, exp);
  endtask

  // Geared steps with signed remainder carried
  task automatic gear_steps(input int s, input bit neg);
    for (int i = 0; i < s; i++)
    begin
      rem = rem + (neg ? -num : num);
      q = rem / den;
      expErr = expErr + q;
      rem = rem - q * den;
    end
  endtask

  task automatic cfg(input int form, input int inv, input int act);
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_PULSECFG, {20'h0, 4'(inv), 4'(form), 4'(act)});
    hp.setup(inv);
    apb(1'b1, `OFS_MODE, 32'h1);
    expErr = 0;
    rem = 0;
  endtask

  task automatic run(input int form, input int n, input bit neg);
    hp.send(form, n, neg);
    gear_steps(form < 2 ? n : n * (1 << (form - 2)), neg);
    wait_chk(expErr[31:0]);
  endtask

  // Watchdog
  initial
  begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("Error %0t watchdog expired", $time);
    finish_test;
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, encA, encB, overtravel, zeroClamp} = 7'h00;
    servoOn = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    inTerm_n = 8'hFF;
    errors = 0;
    n_compared = 0;
    void'($urandom(32'h07C79B23));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values and unmapped refusal
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i]);
      chk({31'h0, er}, 32'(i == 5));
    end
    chk({31'h0, posLoopEnable}, 32'h0);
    num = $urandom_range(100, 1);
    den = $urandom_range(100, 1);
    apb(1'b1, `OFS_GEARNUM, num);
    apb(1'b1, `OFS_GEARDEN, den);
    apb(1'b1, `OFS_GEARNUM, 32'h0);
    apb(1'b0, `OFS_GEARNUM, 32'h0);
    chk(rd, num);
    apb(1'b1, `OFS_MODE, 32'h0001_0000);
    // Every form and inversion, both directions
    for (int f = 0; f < 5; f++)
      for (int v = 0; v < 2; v++)
      begin
        cfg(f, v, 1);
        @(posedge clk);
        chk({31'h0, posLoopEnable}, 32'h1);
        run(f, $urandom_range(5, 1), 1'b0);
        run(f, $urandom_range(5, 1), 1'b1);
      end
    // Encoder cycle counts four, gear shadow not yet active
    cfg(0, 1, 1);
    apb(1'b1, `OFS_GEARNUM, num + 1);
    run(0, 3, 1'b0);
    for (int e = 0; e < 4; e++)
    begin
      @(posedge clk);
      encA <= (e < 2);
      encB <= (e == 1 || e == 2);
      repeat (7) @(posedge clk);
    end
    expErr = expErr - 4;
    wait_chk(expErr[31:0]);
    apb(1'b0, `OFS_ERROR, 32'h0);
    chk(rd, expErr[31:0]);
    // Clear through distributed terminal
    apb(1'b1, `OFS_INDIST, 32'h3);
    @(posedge clk);
    inTerm_n[3] <= 1'b0;
    repeat (`CLEAR_HOLD_CYC) @(posedge clk);
    wait_chk(32'h0);
    chk({31'h0, posLoopEnable}, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h0000000E);
    inTerm_n[3] <= 1'b1;
    // Clear action codes against drive states
    for (int i = 0; i < 5; i++)
    begin
      cfg(0, 1, at[i][0]);
      run(0, 3, 1'b0);
      servoOn <= at[i][1][0];
      overtravel <= at[i][2][0];
      zeroClamp <= at[i][3][0];
      wait_chk(zr[i] ? 32'h0 : expErr[31:0]);
      if (zr[i])
        chk({31'h0, posLoopEnable}, 32'h0);
      // servo on settles before next pulses
      servoOn <= 1'b1;
      overtravel <= 1'b0;
      zeroClamp <= 1'b0;
    end
    finish_test;
  end
endmodule // pulse_train_position_reference_tb
`default_nettype wire
